// ===== core/irq_out_pkg.sv
// Constants for the interrupt request output block.
// Assumes a single 100 MHz core clock and a 16-bit register port.
package irq_out_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] MODE_CONTROL_OFS   = 8'h0c;
  localparam logic [7:0] IRQ_PIN_CONFIG_OFS = 8'h10;
  localparam logic [7:0] USB_IRQ_ENABLE_OFS = 8'h14;
  localparam logic [7:0] USB_IRQ_STATUS_OFS = 8'h18;
  localparam logic [7:0] DMA_IRQ_REASON_OFS = 8'h50;
  localparam logic [7:0] DMA_IRQ_ENABLE_OFS = 8'h54;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int GLOBAL_IRQ_ENABLE_BIT = 3;
  localparam int SIGNAL_MODE_BIT       = 0;
  localparam int POLARITY_BIT          = 1;
  localparam int CTRL_MODE_LSB         = 2;
  localparam int IN_MODE_LSB           = 4;
  localparam int OUT_MODE_LSB          = 6;
  localparam int CTRL_PIPE_BIT         = 8;
  localparam int IN_PIPE_BIT           = 10;
  localparam int OUT_PIPE_BIT          = 11;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] MODE_CONTROL_RST   = 16'h0000;
  localparam logic [7:0]  IRQ_PIN_CONFIG_RST = 8'h00;
  localparam logic [15:0] ENABLE_RST         = 16'h0000;

  // Pipe signalling modes
  localparam logic [1:0] PIPE_ACK_ONLY = 2'h0;
  localparam logic [1:0] PIPE_ACK_NAK  = 2'h1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_NS      = 60;
  localparam int PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ===== core/irq_pulse_gen.sv
// One-shot pulse generator for the request pin in pulse mode.
// Assumes start is a synchronous one-cycle pulse on core_clk.
`timescale 1ns/1ps
module irq_pulse_gen #(
  parameter int PULSE_CYC = irq_out_pkg::PULSE_CYC
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Control
  input  wire logic start,
  output logic      active
);

  typedef struct packed {
    logic       busy;
    logic [7:0] cnt;
  } pulse_state_t;

  pulse_state_t st_ff;
  pulse_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (st_ff.busy) begin
      if (st_ff.cnt == 8'h01) begin
        nxt_st.busy = 1'b0;
      end
      nxt_st.cnt = st_ff.cnt - 8'h01;
    end else if (start) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt  = 8'(PULSE_CYC);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign active = st_ff.busy;

endmodule

// ===== core/usb_peripheral_irq_output.sv
// Interrupt request logic: status, enables, pin configuration, pin drive.
// Assumes events are one-cycle pulses on core_clk and a synchronous
// 16-bit register port driven by logic on the same clock.
//
// What this block does
// [R1] Config register bits set request pin polarity and level or pulse mode.
// [R2] Mode register global enable gates whether the pin may go active.
// [R3] After reset the pin is active low and in level mode.
// [R4] Pulse mode emits one 60 ns pulse per rise of the pending OR.
// [R5] USB events and DMA events each set their own status bit.
// [R6] A status bit counts only when its matching enable bit is set.
// [R7] Three two-bit fields shape signalling for control, IN, OUT pipes.
// [R8] Level mode: event with global enable low sets status, not the pin.
// [R9] Level mode: raising global enable with pending status asserts at once.
// [R10] Level mode: dropping global enable alone does not release the pin.
// [R11] Pin releases once all pending enabled status bits are cleared.
// [R12] Host writes every byte of a status register when clearing.
// [R13] Raw request is OR of enabled bits, driven with programmed polarity.
`timescale 1ns/1ps
module usb_peripheral_irq_output #(
  parameter int PULSE_CYC = irq_out_pkg::PULSE_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic [1:0]  reg_be,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // Event sources
  input  wire logic [15:0] usb_event,
  input  wire logic [15:0] dma_event,
  input  wire logic [2:0]  pipe_nak_event,
  // Request pin
  output logic             irq_pin
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0] mode_control;
    logic [7:0]  irq_pin_config;
    logic [15:0] usb_enable;
    logic [15:0] usb_status;
    logic [15:0] dma_reason;
    logic [15:0] dma_enable;
    logic        asserted;
    logic        raw_prev;
    logic        pin;
    logic [15:0] rdata;
  } irq_state_t;

  irq_state_t st_ff;
  irq_state_t nxt_st;

  logic        raw_or;
  logic        pulse_start;
  logic        pulse_act;
  logic        gie;
  logic        pulse_mode;
  logic        nxt_act;
  logic [15:0] usb_set;
  logic [15:0] usb_clr;
  logic [15:0] dma_clr;

  // Byte-lane write mask: only lanes whose enable is set take effect
  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // Pipe events that the pipe's mode field admits
  function automatic logic pipe_nak_ok(input logic [1:0] mode,
                                       input logic       nak);
    pipe_nak_ok = nak && (mode != irq_out_pkg::PIPE_ACK_ONLY);
  endfunction

  assign gie        = st_ff.mode_control[irq_out_pkg::GLOBAL_IRQ_ENABLE_BIT];
  assign pulse_mode = st_ff.irq_pin_config[irq_out_pkg::SIGNAL_MODE_BIT];
  assign raw_or     = |((st_ff.usb_status & st_ff.usb_enable)
                      | (st_ff.dma_reason & st_ff.dma_enable)); // [R6] [R13]
  // Pulse fires on a rise of the pending OR while globally enabled
  assign pulse_start = pulse_mode && gie && raw_or && !st_ff.raw_prev; // [R4]

  irq_pulse_gen #(
    .PULSE_CYC (PULSE_CYC)
  ) u_pulse (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .start    (pulse_start),
    .active   (pulse_act)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    usb_set = usb_event;
    // Pipe NAK events land on the pipe bit only when the mode admits them
    usb_set[irq_out_pkg::CTRL_PIPE_BIT] = usb_event[irq_out_pkg::CTRL_PIPE_BIT]
      | pipe_nak_ok(st_ff.irq_pin_config[irq_out_pkg::CTRL_MODE_LSB +: 2],
                    pipe_nak_event[0]); // [R7]
    usb_set[irq_out_pkg::IN_PIPE_BIT] = usb_event[irq_out_pkg::IN_PIPE_BIT]
      | pipe_nak_ok(st_ff.irq_pin_config[irq_out_pkg::IN_MODE_LSB +: 2],
                    pipe_nak_event[1]); // [R7]
    usb_set[irq_out_pkg::OUT_PIPE_BIT] = usb_event[irq_out_pkg::OUT_PIPE_BIT]
      | pipe_nak_ok(st_ff.irq_pin_config[irq_out_pkg::OUT_MODE_LSB +: 2],
                    pipe_nak_event[2]); // [R7]
    usb_clr = '0;
    dma_clr = '0;

    if (reg_wr) begin
      case (reg_addr)
        irq_out_pkg::MODE_CONTROL_OFS: begin
          nxt_st.mode_control = (st_ff.mode_control & ~lane_mask(reg_be))
                              | (reg_wdata & lane_mask(reg_be)); // [R2]
        end
        irq_out_pkg::IRQ_PIN_CONFIG_OFS: begin
          if (reg_be[0]) begin
            nxt_st.irq_pin_config = reg_wdata[7:0]; // [R1] [R7]
          end
        end
        irq_out_pkg::USB_IRQ_ENABLE_OFS: begin
          nxt_st.usb_enable = (st_ff.usb_enable & ~lane_mask(reg_be))
                            | (reg_wdata & lane_mask(reg_be)); // [R6]
        end
        irq_out_pkg::DMA_IRQ_ENABLE_OFS: begin
          nxt_st.dma_enable = (st_ff.dma_enable & ~lane_mask(reg_be))
                            | (reg_wdata & lane_mask(reg_be)); // [R6]
        end
        // A partial write clears only its own lanes; software must write
        // both bytes to be sure the pin can fall
        irq_out_pkg::USB_IRQ_STATUS_OFS: begin
          usb_clr = reg_wdata & lane_mask(reg_be); // [R12]
        end
        irq_out_pkg::DMA_IRQ_REASON_OFS: begin
          dma_clr = reg_wdata & lane_mask(reg_be); // [R12]
        end
        default: begin
        end
      endcase
    end

    // Set wins over a clear in the same cycle
    nxt_st.usb_status = (st_ff.usb_status & ~usb_clr) | usb_set; // [R5]
    nxt_st.dma_reason = (st_ff.dma_reason & ~dma_clr) | dma_event; // [R5]

    if (reg_rd) begin
      case (reg_addr)
        irq_out_pkg::MODE_CONTROL_OFS:   nxt_st.rdata = st_ff.mode_control;
        irq_out_pkg::IRQ_PIN_CONFIG_OFS: nxt_st.rdata = {8'h00,
                                                         st_ff.irq_pin_config};
        irq_out_pkg::USB_IRQ_ENABLE_OFS: nxt_st.rdata = st_ff.usb_enable;
        irq_out_pkg::USB_IRQ_STATUS_OFS: nxt_st.rdata = st_ff.usb_status;
        irq_out_pkg::DMA_IRQ_REASON_OFS: nxt_st.rdata = st_ff.dma_reason;
        irq_out_pkg::DMA_IRQ_ENABLE_OFS: nxt_st.rdata = st_ff.dma_enable;
        default:                         nxt_st.rdata = 16'h0000;
      endcase
    end

    // Level latch: only the global enable can raise it, only an empty
    // pending OR can drop it, so clearing the enable leaves it standing
    if (!raw_or) begin
      nxt_st.asserted = 1'b0; // [R11]
    end else if (gie) begin
      nxt_st.asserted = 1'b1; // [R2] [R9]
    end // [R8] [R10]
    nxt_st.raw_prev = raw_or;

    nxt_act = pulse_mode ? pulse_act : nxt_st.asserted;
    // Polarity bit set means active high; cleared means active low
    nxt_st.pin = st_ff.irq_pin_config[irq_out_pkg::POLARITY_BIT]
               ? nxt_act : !nxt_act; // [R1] [R13]
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff.mode_control   <= irq_out_pkg::MODE_CONTROL_RST;
      st_ff.irq_pin_config <= irq_out_pkg::IRQ_PIN_CONFIG_RST; // [R3]
      st_ff.usb_enable     <= irq_out_pkg::ENABLE_RST;
      st_ff.usb_status     <= 16'h0000;
      st_ff.dma_reason     <= 16'h0000;
      st_ff.dma_enable     <= irq_out_pkg::ENABLE_RST;
      st_ff.asserted       <= 1'b0;
      st_ff.raw_prev       <= 1'b0;
      st_ff.pin            <= 1'b1; // [R3]
      st_ff.rdata          <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign irq_pin   = st_ff.pin;
  assign reg_rdata = st_ff.rdata;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  gate_off_a: assert property ( // [R8]
    (!pulse_mode && !gie && !st_ff.asserted
     && !(reg_wr && reg_addr == irq_out_pkg::MODE_CONTROL_OFS))
    |=> !st_ff.asserted)
    else $error("request latched while globally disabled");

  enable_asserts_a: assert property ( // [R9]
    (gie && raw_or) |=> st_ff.asserted)
    else $error("pending enabled status did not assert request");

  level_hold_a: assert property ( // [R10]
    (st_ff.asserted && raw_or) |=> st_ff.asserted)
    else $error("request dropped while status still pending");

  release_a: assert property ( // [R11]
    !raw_or |=> !st_ff.asserted)
    else $error("request held with nothing pending");

  pin_polarity_a: assert property ( // [R13]
    1'b1 |=> irq_pin == ($past(st_ff.irq_pin_config[irq_out_pkg::POLARITY_BIT])
                         ? $past(nxt_act) : !$past(nxt_act)))
    else $error("pin level disagrees with polarity");

  pulse_width_a: assert property ( // [R4]
    $rose(pulse_act) |-> pulse_act [*6] ##1 !pulse_act)
    else $error("pulse width is not six cycles");

  status_set_a: assert property ( // [R5]
    (dma_event != 16'h0000)
    |=> (st_ff.dma_reason & $past(dma_event)) == $past(dma_event))
    else $error("event lost from status");

  mask_off_a: assert property ( // [R6]
    (st_ff.usb_enable == 16'h0000 && st_ff.dma_enable == 16'h0000)
    |-> !raw_or ##1 !st_ff.asserted)
    else $error("masked status raised request");

  usb_set_a: assert property ( // [R5]
    (usb_event != 16'h0000)
    |=> (st_ff.usb_status & $past(usb_event)) == $past(usb_event))
    else $error("usb event lost from status");

  // Clears are checked only when no event races them; a racing set wins
  usb_clear_a: assert property ( // [R11]
    (reg_wr && reg_addr == irq_out_pkg::USB_IRQ_STATUS_OFS
     && reg_be == 2'h3 && usb_event == 16'h0000
     && pipe_nak_event == 3'h0)
    |=> (st_ff.usb_status & $past(reg_wdata)) == 16'h0000)
    else $error("written status bits not cleared");

  dma_clear_a: assert property ( // [R11]
    (reg_wr && reg_addr == irq_out_pkg::DMA_IRQ_REASON_OFS
     && reg_be == 2'h3 && dma_event == 16'h0000)
    |=> (st_ff.dma_reason & $past(reg_wdata)) == 16'h0000)
    else $error("written reason bits not cleared");

  enable_write_a: assert property ( // [R6]
    (reg_wr && reg_addr == irq_out_pkg::USB_IRQ_ENABLE_OFS
     && reg_be == 2'h3)
    |=> st_ff.usb_enable == $past(reg_wdata))
    else $error("usb enable write not taken");

  config_write_a: assert property ( // [R1]
    (reg_wr && reg_addr == irq_out_pkg::IRQ_PIN_CONFIG_OFS && reg_be[0])
    |=> st_ff.irq_pin_config == $past(reg_wdata[7:0]))
    else $error("pin config write not taken");

  config_keep_a: assert property ( // [R1]
    !(reg_wr && reg_addr == irq_out_pkg::IRQ_PIN_CONFIG_OFS && reg_be[0])
    |=> $stable(st_ff.irq_pin_config))
    else $error("pin config changed without a write");

  gie_write_a: assert property ( // [R2]
    (reg_wr && reg_addr == irq_out_pkg::MODE_CONTROL_OFS && reg_be[0])
    |=> gie == $past(reg_wdata[irq_out_pkg::GLOBAL_IRQ_ENABLE_BIT]))
    else $error("global enable write not taken");

  pulse_cause_a: assert property ( // [R4]
    $rose(pulse_act)
    |-> $past(pulse_mode) && $past(gie) && $past(raw_or) && !$past(raw_or, 2))
    else $error("pulse without a rise of the pending OR");

  // Only the control pipe field is watched; the IN and OUT fields share
  // the same decoding function
  pipe_mask_a: assert property ( // [R7]
    (pipe_nak_event[0] && !usb_event[irq_out_pkg::CTRL_PIPE_BIT]
     && !st_ff.usb_status[irq_out_pkg::CTRL_PIPE_BIT]
     && st_ff.irq_pin_config[irq_out_pkg::CTRL_MODE_LSB +: 2]
        == irq_out_pkg::PIPE_ACK_ONLY)
    |=> !st_ff.usb_status[irq_out_pkg::CTRL_PIPE_BIT])
    else $error("ack-only pipe took a nak event");

  pipe_admit_a: assert property ( // [R7]
    (pipe_nak_event[0]
     && st_ff.irq_pin_config[irq_out_pkg::CTRL_MODE_LSB +: 2]
        != irq_out_pkg::PIPE_ACK_ONLY)
    |=> st_ff.usb_status[irq_out_pkg::CTRL_PIPE_BIT])
    else $error("nak event lost on admitting pipe");

endmodule

// ===== test/irq_host_model.sv
// Host processor model: drives the register port and services requests.
// Assumes the device samples the strobes on the rising edge of core_clk.
`timescale 1ns/1ps
module irq_host_model (
  // Clock
  input  wire logic        core_clk,
  // Register port toward the device
  output logic [7:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic [1:0]       reg_be,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata,
  // Request pin from the device
  input  wire logic        irq_pin
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    reg_be    = 2'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // Both lanes always go out, so a clear never leaves half a register set
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk) #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_be    = 2'h3;
    reg_wr    = 1'b1;
    @(posedge core_clk) #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask

  // Read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk) #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge core_clk) #1;
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask

  // Waits a bounded time for the request; if it is seen, clears both registers
  task automatic service(input logic act_lvl, input int limit,
                         output logic seen);
    int k;
    seen = 1'b0;
    k    = 0;
    while (k < limit && !seen) begin
      @(posedge core_clk) #1;
      seen = (irq_pin === act_lvl);
      k++;
    end
    if (seen) begin
      wr(8'h18, 16'hffff);
      wr(8'h50, 16'hffff);
    end
  endtask
endmodule

// ===== test/usb_peripheral_irq_output_bench.sv
// Self-checking bench for the interrupt request output block.
// Assumes the host model owns the register port; events come from here.
`timescale 1ns/1ps
module usb_peripheral_irq_output_bench;
  logic        core_clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [1:0]  reg_be;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] usb_event;
  logic [15:0] dma_event;
  logic [2:0]  pipe_nak_event;
  logic        irq_pin;
  logic [15:0] rv;
  logic        ok;
  logic [64:0] rows [4];
  int          pbit [3];
  int          fails;
  int          num_checks;
  int          n;

  usb_peripheral_irq_output usb_peripheral_irq_output_inst (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .usb_event(usb_event),
    .dma_event(dma_event), .pipe_nak_event(pipe_nak_event),
    .irq_pin(irq_pin));

  irq_host_model irq_host_model_inst (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_pin(irq_pin));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One-cycle event pulse; returns when a level-mode pin has had time to react
  task automatic ev(input logic [15:0] u, input logic [15:0] d,
                    input logic [2:0] k);
    @(posedge core_clk) #1;
    usb_event      = u;
    dma_event      = d;
    pipe_nak_event = k;
    @(posedge core_clk) #1;
    usb_event      = 16'h0000;
    dma_event      = 16'h0000;
    pipe_nak_event = 3'h0;
    @(posedge core_clk) #1;
  endtask

  task automatic clr();
    irq_host_model_inst.wr(irq_out_pkg::USB_IRQ_STATUS_OFS, 16'hffff);
    irq_host_model_inst.wr(irq_out_pkg::DMA_IRQ_REASON_OFS, 16'hffff);
    @(posedge core_clk) #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    irq_host_model_inst.wr(a, d);
  endtask

  initial begin
    fails = 0;
    num_checks = 0;
    rst_n = 1'b0;
    usb_event = 16'h0000;
    dma_event = 16'h0000;
    pipe_nak_event = 3'h0;
    pbit = '{irq_out_pkg::CTRL_PIPE_BIT, irq_out_pkg::IN_PIPE_BIT,
             irq_out_pkg::OUT_PIPE_BIT};
    // usb enable, dma enable, usb event, dma event, expected pin
    rows[0] = {16'h0001, 16'h0000, 16'h0001, 16'h0000, 1'b0};
    rows[1] = {16'h0002, 16'h0000, 16'h0001, 16'h0000, 1'b1};
    rows[2] = {16'h0000, 16'h8000, 16'h0000, 16'h8000, 1'b0};
    rows[3] = {16'h0000, 16'h0001, 16'h0000, 16'h0002, 1'b1};
    repeat (16) @(posedge core_clk);
    #1 rst_n = 1'b1;
    chk(16'(irq_pin), 16'h0001);
    irq_host_model_inst.rd(irq_out_pkg::IRQ_PIN_CONFIG_OFS, rv);
    chk(rv, 16'h0000);
    irq_host_model_inst.rd(8'h3f, rv);
    chk(rv, 16'h0000);
    wr(irq_out_pkg::MODE_CONTROL_OFS, 16'h0008);
    for (int i = 0; i < 4; i++) begin
      wr(irq_out_pkg::USB_IRQ_ENABLE_OFS, rows[i][64:49]);
      wr(irq_out_pkg::DMA_IRQ_ENABLE_OFS, rows[i][48:33]);
      ev(rows[i][32:17], rows[i][16:1], 3'h0);
      chk(16'(irq_pin), 16'(rows[i][0]));
      irq_host_model_inst.rd(irq_out_pkg::USB_IRQ_STATUS_OFS, rv);
      chk(rv, rows[i][32:17]);
      irq_host_model_inst.rd(irq_out_pkg::DMA_IRQ_REASON_OFS, rv);
      chk(rv, rows[i][16:1]);
      clr();
      chk(16'(irq_pin), 16'h0001);
    end
    // Global enable sequence in level mode
    wr(irq_out_pkg::USB_IRQ_ENABLE_OFS, 16'h0001);
    wr(irq_out_pkg::MODE_CONTROL_OFS, 16'h0000);
    ev(16'h0001, 16'h0000, 3'h0);
    chk(16'(irq_pin), 16'h0001);
    wr(irq_out_pkg::MODE_CONTROL_OFS, 16'h0008);
    @(posedge core_clk) #1;
    chk(16'(irq_pin), 16'h0000);
    wr(irq_out_pkg::MODE_CONTROL_OFS, 16'h0000);
    @(posedge core_clk) #1;
    chk(16'(irq_pin), 16'h0000);
    wr(irq_out_pkg::MODE_CONTROL_OFS, 16'h0008);
    wr(irq_out_pkg::IRQ_PIN_CONFIG_OFS, 16'h0002);
    @(posedge core_clk) #1;
    chk(16'(irq_pin), 16'h0001);
    clr();
    chk(16'(irq_pin), 16'h0000);
    // Pulse mode, active low: count the cycles the pin is active
    wr(irq_out_pkg::IRQ_PIN_CONFIG_OFS, 16'h0001);
    ev(16'h0001, 16'h0000, 3'h0);
    n = 0;
    repeat (12) begin
      if (irq_pin === 1'b0)
        n++;
      @(posedge core_clk) #1;
    end
    chk(16'(n), 16'(irq_out_pkg::PULSE_CYC));
    clr();
    // NAK events reach a pipe bit only when the pipe mode admits them
    for (int p = 0; p < 3; p++) begin
      for (int m = 0; m < 4; m++) begin
        wr(irq_out_pkg::IRQ_PIN_CONFIG_OFS,
           16'(m) << (irq_out_pkg::CTRL_MODE_LSB + 2 * p));
        ev(16'h0000, 16'h0000, 3'(1 << p));
        irq_host_model_inst.rd(irq_out_pkg::USB_IRQ_STATUS_OFS, rv);
        chk(rv, 16'(m != 0) << pbit[p]);
        clr();
      end
    end
    // Host services a DMA request; the active-low pin goes back high once it is cleared
    wr(irq_out_pkg::DMA_IRQ_ENABLE_OFS, 16'h0004);
    ev(16'h0000, 16'h0004, 3'h0);
    irq_host_model_inst.service(1'b0, 8, ok);
    chk(16'(ok), 16'h0001);
    @(posedge core_clk) #1;
    chk(16'(irq_pin), 16'h0001);
    // Reset in mid-run with a request standing
    ev(16'h0001, 16'h0000, 3'h0);
    chk(16'(irq_pin), 16'h0000);
    @(posedge core_clk) #1;
    rst_n = 1'b0;
    #1;
    chk(16'(irq_pin), 16'h0001);
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    chk(16'(irq_pin), 16'h0001);
    irq_host_model_inst.rd(irq_out_pkg::MODE_CONTROL_OFS, rv);
    chk(rv, 16'h0000);
    irq_host_model_inst.rd(irq_out_pkg::USB_IRQ_STATUS_OFS, rv);
    chk(rv, 16'h0000);
    end_sim();
  end

  initial begin
    #500000;
    fails++;
    end_sim();
  end
endmodule
